// File: hw/eac_regs.svh
// register offsets, field positions, reset values and timing counts of the
// byte-wide nonvolatile access controller.
// assumes inclusion by bare name from the package and the controller files.
`ifndef EAC_REGS_SVH
`define EAC_REGS_SVH

// register offsets on the plain register port
`define EAC_REG_ADDR_BITS   4
`define EAC_OFS_ADDR_HIGH   4'h0
`define EAC_OFS_ADDR_LOW    4'h1
`define EAC_OFS_BYTE_DATA   4'h2
`define EAC_OFS_CONTROL     4'h3

// control register field positions
`define EAC_CTL_READ_BIT    0
`define EAC_CTL_WRITE_BIT   1
`define EAC_CTL_MASTER_BIT  2
`define EAC_CTL_IRQEN_BIT   3

// array geometry and reset values
`define EAC_ADDR_BITS       12
`define EAC_ARRAY_DEPTH     4096
`define EAC_DATA_RESET      8'h00
`define EAC_RSVD_NIBBLE     4'h0

// timing: core clock, nominal write time and oscillator cycle count
`define EAC_CORE_CLK_KHZ    20000
`define EAC_WRITE_TIME_US   8500
`define EAC_WRITE_RC_CYCLES 67584
`define EAC_WRITE_CNT_BITS  17
`define EAC_RC_DIV_RAW      ((`EAC_CORE_CLK_KHZ * `EAC_WRITE_TIME_US) / (1000 * `EAC_WRITE_RC_CYCLES))
`define EAC_RC_DIV          ((`EAC_RC_DIV_RAW < 1) ? 1 : `EAC_RC_DIV_RAW)
`define EAC_RC_CNT_BITS     8

// core-clock cycle counts
`define EAC_MWE_CYCLES      3'h4
`define EAC_WR_STALL_CYCLES 3'h2
`define EAC_RD_STALL_CYCLES 3'h4

`endif

// File: hw/eac_pkg.sv
// types shared by the nonvolatile access controller files.
// assumes the register header is on the include path.
`include "eac_regs.svh"

package eac_pkg;

	// write engine states
	typedef enum logic {
		ST_IDLE,
		ST_PROG
	} eac_wr_state_t;

	// address and byte captured when a write starts
	typedef struct packed {
		logic [`EAC_ADDR_BITS-1:0] addr;
		logic [7:0]                data;
	} eac_job_t;

endpackage

// File: hw/eac_rc_tick.sv
// divider that stands in for the calibrated rc oscillator: one-cycle tick.
// assumes only the power-on reset stops it, so a running write keeps time.
`timescale 1ns/10ps
`include "eac_regs.svh"

module eac_rc_tick (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	output logic      o_tick
);

	localparam logic [`EAC_RC_CNT_BITS-1:0] LP_LAST = `EAC_RC_CNT_BITS'(`EAC_RC_DIV - 1);

	logic [`EAC_RC_CNT_BITS-1:0] cnt_q;

	// free-running count, tick on the last step
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end else if (cnt_q == LP_LAST) begin
			cnt_q  <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 1'b1;
			o_tick <= 1'b0;
		end
	end

endmodule

// File: hw/eac_cell_array.sv
// flip-flop byte array standing for the nonvolatile cells.
// assumes one write port clocked by the core clock and an untimed read port.
`timescale 1ns/10ps
`include "eac_regs.svh"

module eac_cell_array (
	input  wire logic                      i_core_clk,
	input  wire logic                      i_wr_en,
	input  wire logic [`EAC_ADDR_BITS-1:0] i_wr_addr,
	input  wire logic [7:0]                i_wr_data,
	input  wire logic [`EAC_ADDR_BITS-1:0] i_rd_addr,
	output logic      [7:0]                o_rd_data
);

	// contents survive every reset, like the real cells
	logic [7:0] mem_q [0:`EAC_ARRAY_DEPTH-1];

	// byte programming
	always_ff @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem_q[i_wr_addr] <= i_wr_data;
		end
	end

	// read at once, by index
	assign o_rd_data = mem_q[i_rd_addr];

endmodule

// File: hw/eac_top.sv
// nonvolatile byte access controller: address, data and control registers,
// timed write engine, processor stall and ready request.
// assumes a register master on the core clock, inputs from logic on the same
// clock, and a separate power-on reset that alone may stop a running write.
`timescale 1ns/10ps
`include "eac_regs.svh"

// Overview of operation
// R1 - upper nibble of address-high and control always reads zero
// R2 - twelve-bit linear byte address from high and low registers
// R3 - address register is not reset; software loads it first
// R4 - data register supplies the byte programmed on a write
// R5 - data register holds the byte fetched on a read
// R6 - ready request held while enabled, global enable set, write idle
// R7 - master write enable clears itself four cycles after being set
// R8 - write-enable set starts nothing unless master enable still set
// R9 - write-enable stays set for the write time, then clears
// R10 - byte write lasts 67584 oscillator cycles, about 8.5 ms; the divide-by-two stand-in makes it about 6.76 ms
// R11 - oscillator tick, not the core clock, times the write
// R12 - a valid write start stalls the processor two cycles
// R13 - read strobe fetches at once, stalls the processor four cycles
// R14 - while writing, reads are refused and address writes ignored
// R15 - no write starts while flash self-programming is busy
// R16 - software waits idle, loads address and data, then unlocks
// R17 - software keeps interrupts off across the unlock sequence
// R18 - software polls write-enable before starting a read
// R19 - a write in progress completes despite a system reset
// R20 - unlock timeout counts core cycles, reloaded when set again
module eac_top #(
	parameter int unsigned P_WRITE_TICKS = `EAC_WRITE_RC_CYCLES
) (
	input  wire logic                         i_core_clk,
	input  wire logic                         i_sys_rst,
	input  wire logic                         i_por_rst,
	input  wire logic [`EAC_REG_ADDR_BITS-1:0] i_reg_addr,
	input  wire logic [7:0]                   i_reg_wdata,
	input  wire logic                         i_reg_wr,
	input  wire logic                         i_reg_rd,
	output logic      [7:0]                   o_reg_rdata,
	input  wire logic                         i_global_irq_enable,
	input  wire logic                         i_self_program_busy,
	output logic                              o_ready_irq,
	output logic                              o_cpu_stall
);

	localparam logic [`EAC_WRITE_CNT_BITS-1:0] LP_WRITE_LOAD =
		`EAC_WRITE_CNT_BITS'(P_WRITE_TICKS - 1);

	// one-hot register select, shared by write and read paths
	function automatic logic [3:0] reg_select(input logic [`EAC_REG_ADDR_BITS-1:0] a);
		logic [3:0] s;
		s = 4'h0;
		case (a)
			`EAC_OFS_ADDR_HIGH: s = 4'h1;
			`EAC_OFS_ADDR_LOW:  s = 4'h2;
			`EAC_OFS_BYTE_DATA: s = 4'h4;
			`EAC_OFS_CONTROL:   s = 4'h8;
			default:            s = 4'h0;
		endcase
		return s;
	endfunction

	logic [`EAC_ADDR_BITS-1:0]      addr_q;
	logic [7:0]                     data_q;
	logic                           irq_en_q;
	logic                           mwe_q;
	logic [2:0]                     mwe_cnt_q;
	logic [2:0]                     stall_cnt_q;
	eac_pkg::eac_wr_state_t         state_q;
	logic [`EAC_WRITE_CNT_BITS-1:0] wcnt_q;
	eac_pkg::eac_job_t              job_q;

	logic [3:0]                     wr_sel;
	logic [3:0]                     rd_sel;
	logic                           ctl_wr;
	logic                           idle;
	logic                           start_write;
	logic                           start_read;
	logic                           rc_tick;
	logic                           cell_wr_en;
	logic [7:0]                     cell_rd_data;
	logic [7:0]                     ctl_view;
	logic [7:0]                     rd_mux;

	// oscillator stand-in, stopped only by power-on reset
	// R11 oscillator times writes
	eac_rc_tick u_rc_tick (
		.i_core_clk (i_core_clk),
		.i_rst      (i_por_rst),
		.o_tick     (rc_tick)
	);

	// cell storage
	eac_cell_array u_cells (
		.i_core_clk (i_core_clk),
		.i_wr_en    (cell_wr_en),
		.i_wr_addr  (job_q.addr),
		.i_wr_data  (job_q.data),
		.i_rd_addr  (addr_q),
		.o_rd_data  (cell_rd_data)
	);

	// access decode
	assign wr_sel = i_reg_wr ? reg_select(i_reg_addr) : 4'h0;
	assign rd_sel = i_reg_rd ? reg_select(i_reg_addr) : 4'h0;
	assign ctl_wr = wr_sel[3] & ~i_sys_rst & ~i_por_rst;
	assign idle   = (state_q == eac_pkg::ST_IDLE);

	// write start qualification
	// R8 needs master enable
	// R15 self-program interlock
	assign start_write = ctl_wr & i_reg_wdata[`EAC_CTL_WRITE_BIT] & mwe_q & idle
		& ~i_self_program_busy;

	// read start qualification
	// R14 no read while writing
	assign start_read = ctl_wr & i_reg_wdata[`EAC_CTL_READ_BIT] & idle;

	// address registers, left unreset on purpose
	// R3 no reset value
	// R2 twelve-bit linear address
	// R14 address frozen while busy
	always_ff @(posedge i_core_clk) begin
		if (wr_sel[0] && idle) begin
			addr_q[`EAC_ADDR_BITS-1:8] <= i_reg_wdata[3:0];
		end
		if (wr_sel[1] && idle) begin
			addr_q[7:0] <= i_reg_wdata;
		end
	end

	// byte data register: loaded by software or by a read
	// R5 read fills data
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			data_q <= `EAC_DATA_RESET;
		end else if (start_read) begin
			data_q <= cell_rd_data;
		end else if (wr_sel[2]) begin
			data_q <= i_reg_wdata;
		end
	end

	// ready request enable
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			irq_en_q <= 1'b0;
		end else if (ctl_wr) begin
			irq_en_q <= i_reg_wdata[`EAC_CTL_IRQEN_BIT];
		end
	end

	// master write enable with its core-cycle timeout
	// R7 four-cycle self clear
	// R20 reload on each set
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			mwe_q     <= 1'b0;
			mwe_cnt_q <= 3'h0;
		end else if (ctl_wr) begin
			mwe_q     <= i_reg_wdata[`EAC_CTL_MASTER_BIT];
			mwe_cnt_q <= i_reg_wdata[`EAC_CTL_MASTER_BIT] ? `EAC_MWE_CYCLES : 3'h0;
		end else if (mwe_q) begin
			if (mwe_cnt_q == 3'h1) begin
				mwe_q     <= 1'b0;
				mwe_cnt_q <= 3'h0;
			end else begin
				mwe_cnt_q <= mwe_cnt_q - 3'h1;
			end
		end
	end

	// write engine; a system reset does not touch it
	// R19 write survives reset
	// R4 data captured for programming
	// R9 busy until time elapsed
	always_ff @(posedge i_core_clk) begin
		if (i_por_rst) begin
			state_q <= eac_pkg::ST_IDLE;
			wcnt_q  <= '0;
			job_q   <= '0;
		end else begin
			case (state_q)
				eac_pkg::ST_IDLE: begin
					if (start_write) begin
						state_q    <= eac_pkg::ST_PROG;
						wcnt_q     <= LP_WRITE_LOAD;
						job_q.addr <= addr_q;
						job_q.data <= data_q;
					end
				end
				eac_pkg::ST_PROG: begin
					// R10 fixed tick count
					if (rc_tick) begin
						if (wcnt_q == '0) begin
							state_q <= eac_pkg::ST_IDLE;
						end else begin
							wcnt_q <= wcnt_q - 1'b1;
						end
					end
				end
				default: begin
					state_q <= eac_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// cells are programmed on the last tick, as busy drops
	assign cell_wr_en = (state_q == eac_pkg::ST_PROG) & rc_tick & (wcnt_q == '0);

	// processor stall after a write start or a read
	// R12 two-cycle write stall
	// R13 four-cycle read stall
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			stall_cnt_q <= 3'h0;
			o_cpu_stall <= 1'b0;
		end else if (start_read) begin
			stall_cnt_q <= `EAC_RD_STALL_CYCLES;
			o_cpu_stall <= 1'b1;
		end else if (start_write) begin
			stall_cnt_q <= `EAC_WR_STALL_CYCLES;
			o_cpu_stall <= 1'b1;
		end else if (stall_cnt_q != 3'h0) begin
			stall_cnt_q <= stall_cnt_q - 3'h1;
			o_cpu_stall <= (stall_cnt_q != 3'h1);
		end else begin
			o_cpu_stall <= 1'b0;
		end
	end

	// ready request, level while the engine is idle
	// R6 continuous ready request
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			o_ready_irq <= 1'b0;
		end else begin
			o_ready_irq <= irq_en_q & i_global_irq_enable & idle;
		end
	end

	// control view; read strobe bit always shows zero
	// R1 reserved nibble zero
	assign ctl_view = {`EAC_RSVD_NIBBLE, irq_en_q, mwe_q, ~idle, 1'b0};

	// read-back select, zero for unmapped offsets
	always_comb begin
		rd_mux = 8'h00;
		case (rd_sel)
			4'h1:    rd_mux = {`EAC_RSVD_NIBBLE, addr_q[`EAC_ADDR_BITS-1:8]};
			4'h2:    rd_mux = addr_q[7:0];
			4'h4:    rd_mux = data_q;
			4'h8:    rd_mux = ctl_view;
			default: rd_mux = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			o_reg_rdata <= 8'h00;
		end else begin
			o_reg_rdata <= rd_mux;
		end
	end

endmodule

// File: verification/eac_top_props.sv
// checker for eac_top: read port, reserved bits, unlock timeout, stall, ready.
// assumes it is bound into eac_top; both resets synchronous, active high.
`timescale 1ns/10ps
`include "eac_regs.svh"
module eac_props #(
	parameter int unsigned P_WRITE_TICKS = 8
) (
	input wire logic                          i_core_clk,
	input wire logic                          i_sys_rst,
	input wire logic                          i_por_rst,
	input wire logic [`EAC_REG_ADDR_BITS-1:0] i_reg_addr,
	input wire logic [7:0]                    i_reg_wdata,
	input wire logic                          i_reg_wr,
	input wire logic                          i_reg_rd,
	input wire logic [7:0]                    o_reg_rdata,
	input wire logic                          i_global_irq_enable,
	input wire logic                          i_self_program_busy,
	input wire logic                          o_ready_irq,
	input wire logic                          o_cpu_stall
);
	logic [2:0] mwe_age_q;
	logic       ctl_wr;
	// control write strobe
	assign ctl_wr = i_reg_wr && (i_reg_addr == `EAC_OFS_CONTROL);
	// cycles since master enable was last written to one, saturating
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || i_por_rst) begin
			mwe_age_q <= 3'h7;
		end else if (ctl_wr) begin
			mwe_age_q <= i_reg_wdata[2] ? 3'h0 : 3'h7;
		end else if (mwe_age_q != 3'h7) begin
			mwe_age_q <= mwe_age_q + 3'h1;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst || i_por_rst);
	property p_rdata_idle;
		!$past(i_reg_rd) |-> o_reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
	property p_rsvd;
		$past(i_reg_rd) && ($past(i_reg_addr) == `EAC_OFS_ADDR_HIGH
			|| $past(i_reg_addr) == `EAC_OFS_CONTROL) |-> o_reg_rdata[7:4] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved nibble not zero");
	property p_unmapped;
		$past(i_reg_rd) && $past(i_reg_addr) > `EAC_OFS_CONTROL |-> o_reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_mwe;
		$past(i_reg_rd) && $past(i_reg_addr) == `EAC_OFS_CONTROL
			|-> o_reg_rdata[2] == ($past(mwe_age_q) < 3'h4);
	endproperty
	a_mwe: assert property (p_mwe) else $error("master enable timeout wrong");
	property p_ctl_rd0;
		$past(i_reg_rd) && $past(i_reg_addr) == `EAC_OFS_CONTROL |-> !o_reg_rdata[0];
	endproperty
	a_ctl_rd0: assert property (p_ctl_rd0) else $error("read strobe bit not zero");
	property p_irq_gate;
		!$past(i_global_irq_enable) |-> !o_ready_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("ready without global enable");
	property p_stall_cause;
		$rose(o_cpu_stall) |-> $past(ctl_wr && (i_reg_wdata[1] || i_reg_wdata[0]));
	endproperty
	a_stall_cause: assert property (p_stall_cause) else $error("stall without start");
	property p_rd_stall;
		$rose(o_cpu_stall) && $past(i_reg_wdata[1:0]) == 2'b01 |-> o_cpu_stall[*4] ##1 !o_cpu_stall;
	endproperty
	a_rd_stall: assert property (p_rd_stall) else $error("read stall not four");
	property p_wr_stall;
		$rose(o_cpu_stall) && $past(i_reg_wdata[1:0]) == 2'b10 |-> o_cpu_stall[*2] ##1 !o_cpu_stall;
	endproperty
	a_wr_stall: assert property (p_wr_stall) else $error("write stall not two");
endmodule
bind eac_top eac_props #(.P_WRITE_TICKS(P_WRITE_TICKS)) u_props (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_por_rst(i_por_rst), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_global_irq_enable(i_global_irq_enable),
	.i_self_program_busy(i_self_program_busy), .o_ready_irq(o_ready_irq),
	.o_cpu_stall(o_cpu_stall));

// File: verification/tb.sv
// bench for eac_top: register port tasks and scripted access sequences.
// assumes the controller files and the checker are compiled before it.
`timescale 1ns/10ps
`include "eac_regs.svh"
module tb;
	logic       clk = 1'b0;
	logic       por = 1'b1;
	logic       srst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wd = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       glb = 1'b0;
	logic       spm = 1'b0;
	logic [7:0] rdata;
	logic       irq;
	logic       stall;
	int         fails = 0;
	int         n_checks = 0;
	// 20 MHz core clock
	always #25 clk = ~clk;
	eac_top #(.P_WRITE_TICKS(12)) DUT (.i_core_clk(clk), .i_sys_rst(srst), .i_por_rst(por),
		.i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_global_irq_enable(glb), .i_self_program_busy(spm),
		.o_ready_irq(irq), .o_cpu_stall(stall));
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// poll busy first; always reads at least once, bounded count
	task automatic wait_idle();
		int i;
		i = 0;
		do begin
			@(posedge clk);
			addr <= `EAC_OFS_CONTROL;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			i++;
		end while (i < 60 && rdata[1] !== 1'b0);
		chk(rdata & 8'h02, 8'h00);
	endtask
	// unlock, then write enable after gap+1 idle cycles
	task automatic start(input int gap, input logic [7:0] ie);
		wreg(`EAC_OFS_CONTROL, 8'h04 | ie);
		repeat (gap) @(posedge clk);
		wreg(`EAC_OFS_CONTROL, 8'h06 | ie);
	endtask
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge clk);
		#1;
		chk({7'h00, irq}, {7'h00, exp});
	endtask
	// count stall cycles right after a control write
	task automatic stall_chk(input logic [7:0] exp);
		logic [7:0] n;
		n = 8'h00;
		#1;
		while (stall === 1'b1 && n < 8'h08) begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(n, exp);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		por <= 1'b0;
		srst <= 1'b0;
		rchk(`EAC_OFS_BYTE_DATA, `EAC_DATA_RESET);
		rchk(`EAC_OFS_CONTROL, 8'h00);
		for (int a = 4; a < 16; a++) begin
			rchk(4'(a), 8'h00);
		end
		wreg(`EAC_OFS_ADDR_HIGH, 8'hf5);
		rchk(`EAC_OFS_ADDR_HIGH, 8'h05);
		wreg(`EAC_OFS_ADDR_LOW, 8'ha3);
		wreg(`EAC_OFS_BYTE_DATA, 8'h3c);
		wreg(`EAC_OFS_CONTROL, 8'hfe);
		rchk(`EAC_OFS_CONTROL, 8'h0c);
		@(posedge clk);
		rchk(`EAC_OFS_CONTROL, 8'h08);
		wreg(`EAC_OFS_CONTROL, 8'h00);
		start(2, 8'h00);
		stall_chk(8'h02);
		rchk(`EAC_OFS_CONTROL, 8'h06);
		wreg(`EAC_OFS_ADDR_LOW, 8'h00);
		wreg(`EAC_OFS_BYTE_DATA, 8'h77);
		wreg(`EAC_OFS_CONTROL, 8'h01);
		stall_chk(8'h00);
		rchk(`EAC_OFS_BYTE_DATA, 8'h77);
		rchk(`EAC_OFS_ADDR_LOW, 8'ha3);
		rchk(`EAC_OFS_CONTROL, 8'h02);
		// twelve ticks of two core cycles: busy drops between these two reads
		repeat (4) @(posedge clk);
		rchk(`EAC_OFS_CONTROL, 8'h02);
		@(posedge clk);
		rchk(`EAC_OFS_CONTROL, 8'h00);
		wait_idle();
		wreg(`EAC_OFS_CONTROL, 8'h01);
		stall_chk(8'h04);
		rchk(`EAC_OFS_BYTE_DATA, 8'h3c);
		wreg(`EAC_OFS_BYTE_DATA, 8'h99);
		start(3, 8'h00);
		stall_chk(8'h00);
		rchk(`EAC_OFS_CONTROL, 8'h04);
		@(posedge clk);
		spm <= 1'b1;
		start(2, 8'h00);
		stall_chk(8'h00);
		rchk(`EAC_OFS_CONTROL, 8'h04);
		@(posedge clk);
		spm <= 1'b0;
		wreg(`EAC_OFS_CONTROL, 8'h01);
		rchk(`EAC_OFS_BYTE_DATA, 8'h3c);
		@(posedge clk);
		glb <= 1'b1;
		wreg(`EAC_OFS_CONTROL, 8'h08);
		irq_chk(1'b1);
		wreg(`EAC_OFS_BYTE_DATA, 8'h5e);
		start(2, 8'h08);
		irq_chk(1'b0);
		@(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		wait_idle();
		wreg(`EAC_OFS_CONTROL, 8'h09);
		rchk(`EAC_OFS_BYTE_DATA, 8'h5e);
		irq_chk(1'b1);
		@(posedge clk);
		glb <= 1'b0;
		irq_chk(1'b0);
		test_done();
	end
	// watchdog well beyond the under two hundred cycles the tests take
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		test_done();
	end
endmodule
